// ===== predicate_compare_ge_unit.sv
// Purpose: predicate-setting compares of the greater-or-equal family
// Assumes: one instruction per cycle from the issue logic, result one cycle later
// Notes: denormals count as zero in every float compare
`timescale 1ns/1ps
module predicate_compare_ge_unit
    import pred_cmp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic issue_valid,
    input wire logic [OPCODE_W-1:0] alu_opcode_field,
    input wire logic pair_high,
    input wire logic [31:0] src0_even,
    input wire logic [31:0] src0_odd,
    input wire logic [31:0] src1_even,
    input wire logic [31:0] src1_odd,
    input wire logic src0_neg,
    input wire logic src0_abs,
    input wire logic src1_neg,
    input wire logic src1_abs,
    output logic result_valid,
    output logic [31:0] dst_even,
    output logic [31:0] dst_odd,
    output logic dst_pair_high,
    output logic predicate_update,
    output logic predicate_execute,
    output logic kill_predicate_update,
    output logic kill_predicate_execute,
    output logic opcode_error
);
    function automatic logic [31:0] apply_mod(input logic [31:0] x, input logic neg, input logic abs_en);
        logic [31:0] r;
        r = x;
        if (abs_en) begin
            r[31] = 1'b0;
        end
        r[31] = r[31] ^ neg;
        return r;
    endfunction : apply_mod

    // ordering key: zeros and denormals collapse to 0, negatives mirror below it
    function automatic logic signed [32:0] key32(input logic [31:0] x);
        if (x[30:23] == 8'h00) begin
            return 33'sd0;
        end
        return x[31] ? -$signed({2'b00, x[30:0]}) : $signed({2'b00, x[30:0]});
    endfunction : key32

    function automatic logic nan32(input logic [31:0] x);
        return (x[30:23] == FP32_EXP_MAX) && (x[22:0] != 23'h000000);
    endfunction : nan32

    function automatic logic signed [64:0] key64(input logic [63:0] x);
        if (x[62:52] == 11'h000) begin
            return 65'sd0;
        end
        return x[63] ? -$signed({2'b00, x[62:0]}) : $signed({2'b00, x[62:0]});
    endfunction : key64

    function automatic logic nan64(input logic [63:0] x);
        return (x[62:52] == FP64_EXP_MAX) && (x[51:0] != 52'h0);
    endfunction : nan64

    logic [31:0] a32;
    logic [31:0] b32;
    logic [63:0] a64;
    logic [63:0] b64;
    logic float_ge;
    logic float_gt;
    logic double_ge;
    logic push_float_ok;
    logic push_int_ok;
    logic [31:0] src0_plus_one;

    assign a32 = apply_mod(src0_even, src0_neg, src0_abs);
    assign b32 = apply_mod(src1_even, src1_neg, src1_abs);
    // modifiers touch only the even slot, which holds the sign and exponent
    assign a64 = {a32, src0_odd};
    assign b64 = {b32, src1_odd};
    assign float_ge = !nan32(a32) && !nan32(b32) && (key32(a32) >= key32(b32));
    assign float_gt = !nan32(a32) && !nan32(b32) && (key32(a32) > key32(b32));
    assign double_ge = !nan64(a64) && !nan64(b64) && (key64(a64) >= key64(b64));
    assign push_float_ok = !nan32(b32) && (key32(b32) >= 33'sd0) && !nan32(a32) && (key32(a32) == 33'sd0);
    assign push_int_ok = !src1_even[31] && !nan32(a32) && (key32(a32) == 33'sd0);

    fp32_add_one u_add_one (
        .operand(a32),
        .sum(src0_plus_one)
    );

    // result datapath, one stage; no output modifier on any path
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result_valid <= 1'b0;
            dst_even <= FP32_ZERO;
            dst_odd <= FP32_ZERO;
            dst_pair_high <= 1'b0;
            opcode_error <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            opcode_error <= 1'b0;
            if (issue_valid) begin
                result_valid <= 1'b1;
                dst_odd <= FP32_ZERO;
                dst_pair_high <= pair_high;
                unique case (alu_opcode_field)
                    OP_FLOAT_GE: dst_even <= float_ge ? FP32_ZERO : FP32_ONE;
                    OP_FLOAT_GT: dst_even <= float_gt ? FP32_ZERO : FP32_ONE;
                    OP_SIGNED_GE: dst_even <= ($signed(src0_even) >= $signed(src1_even)) ? FP32_ZERO : FP32_ONE;
                    OP_UNSIGNED_GE: dst_even <= (src0_even >= src1_even) ? FP32_ZERO : FP32_ONE;
                    OP_FLOAT_GE_PUSH: dst_even <= push_float_ok ? FP32_ZERO : src0_plus_one;
                    OP_INT_GE_PUSH: dst_even <= push_int_ok ? FP32_ZERO : src0_plus_one;
                    OP_DOUBLE_GE: begin
                        dst_even <= double_ge ? INT_TRUE : INT_FALSE;
                        dst_odd <= double_ge ? INT_TRUE : INT_FALSE;
                    end
                    default: begin
                        result_valid <= 1'b0;
                        opcode_error <= 1'b1;
                    end
                endcase
            end
        end
    end

    // predicate state holds until the next predicate op replaces it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            predicate_update <= 1'b0;
            predicate_execute <= 1'b0;
        end else begin
            predicate_update <= 1'b0;
            if (issue_valid) begin
                unique case (alu_opcode_field)
                    OP_FLOAT_GE: begin
                        predicate_update <= 1'b1;
                        predicate_execute <= float_ge;
                    end
                    OP_FLOAT_GT: begin
                        predicate_update <= 1'b1;
                        predicate_execute <= float_gt;
                    end
                    OP_FLOAT_GE_PUSH: begin
                        predicate_update <= 1'b1;
                        predicate_execute <= push_float_ok;
                    end
                    OP_INT_GE_PUSH: begin
                        predicate_update <= 1'b1;
                        predicate_execute <= push_int_ok;
                    end
                    OP_DOUBLE_GE: begin
                        predicate_update <= 1'b1;
                        predicate_execute <= double_ge;
                    end
                    default: predicate_update <= 1'b0;
                endcase
            end
        end
    end

    // signed and unsigned integer compares drive the kill predicate instead
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            kill_predicate_update <= 1'b0;
            kill_predicate_execute <= 1'b0;
        end else begin
            kill_predicate_update <= 1'b0;
            if (issue_valid && alu_opcode_field == OP_SIGNED_GE) begin
                kill_predicate_update <= 1'b1;
                kill_predicate_execute <= $signed(src0_even) >= $signed(src1_even);
            end else if (issue_valid && alu_opcode_field == OP_UNSIGNED_GE) begin
                kill_predicate_update <= 1'b1;
                kill_predicate_execute <= src0_even >= src1_even;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_issue(logic [OPCODE_W-1:0] op);
        issue_valid && alu_opcode_field == op;
    endsequence

    sequence s_answer;
        result_valid && predicate_update;
    endsequence

    a_float_ge_result: assert property (s_issue(OP_FLOAT_GE) |=> s_answer and
        (predicate_execute == $past(float_ge) && dst_even == ($past(float_ge) ? FP32_ZERO : FP32_ONE)))
        else $error("float ge result wrong");
    a_float_gt_result: assert property (s_issue(OP_FLOAT_GT) ##1 s_answer |->
        dst_even == (predicate_execute ? FP32_ZERO : FP32_ONE))
        else $error("float gt result wrong");
    a_double_both_dwords: assert property (s_issue(OP_DOUBLE_GE) |=> s_answer and (dst_even == dst_odd
        && dst_even == (predicate_execute ? INT_TRUE : INT_FALSE) && dst_pair_high == $past(pair_high)))
        else $error("double result dwords wrong");
    a_double_nan_false: assert property (s_issue(OP_DOUBLE_GE) && (nan64(a64) || nan64(b64))
        |=> !predicate_execute && dst_even == INT_FALSE)
        else $error("double nan not false");
    a_double_zero_equal: assert property (s_issue(OP_DOUBLE_GE) && a64[62:52] == 11'h000
        && b64[62:52] == 11'h000 |=> predicate_execute)
        else $error("double zeros not equal");
    a_signed_kill_pred: assert property (s_issue(OP_SIGNED_GE) |=> kill_predicate_update
        && !predicate_update && kill_predicate_execute == (dst_even == FP32_ZERO))
        else $error("signed kill predicate wrong");
    a_unsigned_kill_pred: assert property (s_issue(OP_UNSIGNED_GE) |=> kill_predicate_update
        && kill_predicate_execute == ($past(src0_even) >= $past(src1_even)))
        else $error("unsigned kill predicate wrong");
    a_push_result: assert property ((s_issue(OP_FLOAT_GE_PUSH) or s_issue(OP_INT_GE_PUSH))
        |=> predicate_update && dst_even == (predicate_execute ? FP32_ZERO : $past(src0_plus_one)))
        else $error("push result wrong");
    a_pred_hold: assert property (!predicate_update |=> predicate_update || $stable(predicate_execute))
        else $error("predicate changed without update");
    a_one_outcome: assert property (!issue_valid |=> !result_valid && !predicate_update
        && !kill_predicate_update)
        else $error("outcome without issue");
endmodule : predicate_compare_ge_unit

// ===== pred_cmp_pkg.sv
// Purpose: shared constants for the greater-or-equal predicate compare unit
// Assumes: operands arrive as 32-bit dwords, doubles split into high and low dwords
// Notes: opcode values are the alu_opcode_field encodings
package pred_cmp_pkg;
    localparam int OPCODE_W = 11;
    localparam logic [OPCODE_W-1:0] OP_UNSIGNED_GE = 11'h01F;
    localparam logic [OPCODE_W-1:0] OP_FLOAT_GE = 11'h022;
    localparam logic [OPCODE_W-1:0] OP_FLOAT_GT = 11'h021;
    localparam logic [OPCODE_W-1:0] OP_FLOAT_GE_PUSH = 11'h02A;
    localparam logic [OPCODE_W-1:0] OP_SIGNED_GE = 11'h044;
    localparam logic [OPCODE_W-1:0] OP_INT_GE_PUSH = 11'h04C;
    localparam logic [OPCODE_W-1:0] OP_DOUBLE_GE = 11'h0C9;

    localparam logic [31:0] FP32_ZERO = 32'h00000000;
    localparam logic [31:0] FP32_ONE = 32'h3F800000;
    localparam logic [31:0] INT_TRUE = 32'h00000000;
    localparam logic [31:0] INT_FALSE = 32'hFFFFFFFF;
    localparam logic [7:0] FP32_BIAS = 8'h7F;
    localparam logic [7:0] FP32_EXP_MAX = 8'hFF;
    localparam logic [10:0] FP64_EXP_MAX = 11'h7FF;
    localparam int ADD_LEAD_BIT = 49;
    localparam int ADD_GUARD = 26;
    localparam int LATENCY = 1;

    // which slot pair carries a double-width operation
    typedef enum logic [1:0] {
        PAIR_LOW = 2'b01,
        PAIR_HIGH = 2'b10
    } pair_t;
endpackage : pred_cmp_pkg

// ===== fp32_add_one.sv
// Purpose: single-precision src plus 1.0 for the counter push result
// Assumes: round toward zero, denormal inputs and results flushed to zero
// Notes: purely combinational, the caller registers the sum
`timescale 1ns/1ps
module fp32_add_one
    import pred_cmp_pkg::*;
(
    input wire logic [31:0] operand,
    output logic [31:0] sum
);
    always_comb begin
        logic [7:0] e;
        logic [7:0] ebig;
        logic [7:0] d;
        logic [49:0] mbig;
        logic [49:0] msmall;
        logic [50:0] acc;
        logic [50:0] norm;
        logic sbig;
        logic sub;
        int p;
        int ex;
        e = operand[30:23];
        ebig = FP32_BIAS;
        d = 8'h00;
        mbig = '0;
        msmall = '0;
        acc = '0;
        norm = '0;
        sbig = 1'b0;
        sub = 1'b0;
        p = -1;
        ex = 0;
        sum = operand;
        if (e == FP32_EXP_MAX) begin
            // nan stays nan, infinity absorbs the increment
            sum = operand;
        end else if (e == 8'h00) begin
            sum = FP32_ONE;
        end else begin
            if (e >= FP32_BIAS) begin
                ebig = e;
                d = 8'(e - FP32_BIAS);
                mbig = {1'b1, operand[22:0], 26'h0000000};
                msmall = {1'b1, 23'h000000, 26'h0000000} >> d;
                sbig = operand[31];
                sub = operand[31];
            end else begin
                d = 8'(FP32_BIAS - e);
                mbig = {1'b1, 23'h000000, 26'h0000000};
                msmall = {1'b1, operand[22:0], 26'h0000000} >> d;
                sub = operand[31];
            end
            acc = sub ? ({1'b0, mbig} - {1'b0, msmall}) : ({1'b0, mbig} + {1'b0, msmall});
            for (int i = 0; i < 51; i++) begin
                if (acc[i]) begin
                    p = i;
                end
            end
            ex = int'(ebig) + p - ADD_LEAD_BIT;
            norm = acc << (50 - p);
            if (p < 0) begin
                sum = FP32_ZERO;
            end else if (ex >= 255) begin
                sum = {sbig, FP32_EXP_MAX, 23'h000000};
            end else if (ex <= 0) begin
                sum = {sbig, 31'h00000000};
            end else begin
                sum = {sbig, 8'(ex), norm[49:27]};
            end
        end
    end
endmodule : fp32_add_one

// ===== issue_model.sv
// Purpose: issue logic model, one instruction per cycle into the compare unit
// Assumes: a double sits on one slot pair; two doubles of a bundle go as two cycles
// Notes: operands scramble while idle so stale values never pass as valid
`timescale 1ns/1ps
module issue_model
    import pred_cmp_pkg::*;
(
    input wire logic sys_clk,
    output logic issue_valid,
    output logic [OPCODE_W-1:0] alu_opcode_field,
    output logic pair_high,
    output logic [127:0] src,
    output logic [3:0] mods
);
    task automatic idle();
        issue_valid <= 1'b0;
        src <= {$urandom, $urandom, $urandom, $urandom};
        alu_opcode_field <= OPCODE_W'($urandom);
        mods <= 4'($urandom);
        pair_high <= 1'($urandom);
    endtask : idle

    // gap 0 keeps valid up, so the caller issues again or flushes
    task automatic issue(input logic [OPCODE_W-1:0] op, input logic [127:0] s, input logic [3:0] m,
        input logic ph, input int gap);
        @(posedge sys_clk);
        issue_valid <= 1'b1;
        alu_opcode_field <= op;
        src <= s;
        mods <= m;
        pair_high <= ph;
        repeat (gap) begin
            @(posedge sys_clk);
            idle();
        end
    endtask : issue

    task automatic flush();
        @(posedge sys_clk);
        idle();
    endtask : flush

    initial idle();
endmodule : issue_model

// ===== tb.sv
// Purpose: self-checking bench for the predicate compare unit
// Assumes: result one cycle after the taking edge, modifiers on even dwords of float ops
// Notes: push sums are drawn from a small table of exact values
`timescale 1ns/1ps
module tb
    import pred_cmp_pkg::*;
;
    typedef struct packed {
        logic err, dbl, ph, pu, pe, ku, ke;
        logic [31:0] de, dd;
    } note_t;
    logic sys_clk, rst, issue_valid, pair_high, prev_iv;
    logic [OPCODE_W-1:0] opc;
    logic [127:0] src;
    logic [3:0] mods;
    logic result_valid, dst_pair_high, predicate_update, predicate_execute;
    logic kill_predicate_update, kill_predicate_execute, opcode_error;
    logic [31:0] dst_even, dst_odd;
    logic exp_pe, exp_ke;
    note_t q[$];
    int n_mismatch, checks_done, cyc;
    localparam logic [63:0] DT [10] = '{64'h4018000000000000, 64'h4008000000000000, 64'h7FF0000000000000,
        64'hFFF0000000000000, 64'h7FF8000000000000, 64'h0000000000000001, 64'h8000000000000001,
        64'h8000000000000000, 64'hC008000000000000, 64'h4018000000000001};
    localparam logic [31:0] FT [9] = '{32'h0, 32'h80000000, 32'h00000001, 32'h7F800000, 32'hFF800000,
        32'h7FC00000, 32'h3F800000, 32'h40000000, 32'hC0400000};
    localparam logic [31:0] PT [5] = '{32'h0, 32'h80000001, 32'h40000000, 32'h40400000, 32'hC0000000};
    localparam logic [OPCODE_W-1:0] OPS [9] = '{OP_FLOAT_GE, OP_FLOAT_GT, OP_FLOAT_GE_PUSH, OP_INT_GE_PUSH,
        OP_SIGNED_GE, OP_UNSIGNED_GE, OP_DOUBLE_GE, 11'h020, 11'h7FF};

    issue_model issue_model_i (.sys_clk(sys_clk), .issue_valid(issue_valid), .alu_opcode_field(opc),
        .pair_high(pair_high), .src(src), .mods(mods));
    predicate_compare_ge_unit predicate_compare_ge_unit_i (.sys_clk(sys_clk), .rst(rst),
        .issue_valid(issue_valid), .alu_opcode_field(opc), .pair_high(pair_high),
        .src0_even(src[127:96]), .src0_odd(src[95:64]), .src1_even(src[63:32]), .src1_odd(src[31:0]),
        .src0_neg(mods[3]), .src0_abs(mods[2]), .src1_neg(mods[1]), .src1_abs(mods[0]),
        .result_valid(result_valid), .dst_even(dst_even), .dst_odd(dst_odd), .dst_pair_high(dst_pair_high),
        .predicate_update(predicate_update), .predicate_execute(predicate_execute),
        .kill_predicate_update(kill_predicate_update), .kill_predicate_execute(kill_predicate_execute),
        .opcode_error(opcode_error));

    // denormals flush to zero, NaN never orders; sb is the sign position
    function automatic logic fcmp(input logic [63:0] x, input logic [63:0] y, input int mw, input int sb,
        input logic gt);
        logic [63:0] m, e;
        logic signed [65:0] k [2];
        e = ((64'h1 << sb) - 64'h1) & ~((64'h1 << mw) - 64'h1);
        for (int i = 0; i < 2; i++) begin
            m = (i == 0 ? x : y) & ((64'h1 << sb) - 64'h1);
            if ((m & e) == e && m != e) return 1'b0;
            if ((m & e) == 64'h0) m = 64'h0;
            k[i] = (i == 0 ? x[sb] : y[sb]) ? -$signed({2'b0, m}) : $signed({2'b0, m});
        end
        return gt ? (k[0] > k[1]) : (k[0] >= k[1]);
    endfunction : fcmp

    function automatic logic [31:0] apply_mods(input logic [31:0] v, input logic [1:0] nm);
        return {(v[31] & ~nm[0]) ^ nm[1], v[30:0]};
    endfunction : apply_mods

    function automatic logic [31:0] plus1(input logic [31:0] v);
        case (v)
            32'h40000000: return 32'h40400000;
            32'h40400000: return 32'h40800000;
            32'hC0000000: return 32'hBF800000;
            32'hC0400000: return 32'hC0000000;
            default: return FP32_ONE;
        endcase
    endfunction : plus1

    task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask : cmp_word

    task automatic cmp_bit(input string what, input logic e, input logic s);
        cmp_word(what, {31'h0, e}, {31'h0, s});
    endtask : cmp_bit

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic send(input logic [OPCODE_W-1:0] op, input logic [127:0] s, input logic [3:0] m,
        input logic ph, input int gap);
        logic [31:0] a, b;
        logic t, z;
        note_t n;
        a = apply_mods(s[127:96], m[3:2]);
        b = apply_mods(s[63:32], m[1:0]);
        z = fcmp({32'h0, a}, 64'h0, 23, 31, 1'b0) && fcmp(64'h0, {32'h0, a}, 23, 31, 1'b0);
        n = '0;
        t = 1'b0;
        case (op)
            OP_FLOAT_GE: t = fcmp({32'h0, a}, {32'h0, b}, 23, 31, 1'b0);
            OP_FLOAT_GT: t = fcmp({32'h0, a}, {32'h0, b}, 23, 31, 1'b1);
            OP_SIGNED_GE: t = $signed(s[127:96]) >= $signed(s[63:32]);
            OP_UNSIGNED_GE: t = s[127:96] >= s[63:32];
            OP_FLOAT_GE_PUSH: t = z && fcmp({32'h0, b}, 64'h0, 23, 31, 1'b0);
            OP_INT_GE_PUSH: t = z && !s[63];
            OP_DOUBLE_GE: t = fcmp({a, s[95:64]}, {b, s[31:0]}, 52, 63, 1'b0);
            default: n.err = 1'b1;
        endcase
        n.dbl = op == OP_DOUBLE_GE;
        n.ph = ph;
        n.de = n.dbl ? (t ? INT_TRUE : INT_FALSE) : (t ? FP32_ZERO : FP32_ONE);
        if (!t && (op == OP_FLOAT_GE_PUSH || op == OP_INT_GE_PUSH)) n.de = plus1(a);
        n.dd = n.dbl ? n.de : 32'h0;
        n.ku = !n.err && (op == OP_SIGNED_GE || op == OP_UNSIGNED_GE);
        n.pu = !n.err && !n.ku;
        if (n.pu) exp_pe = t;
        if (n.ku) exp_ke = t;
        n.pe = exp_pe;
        n.ke = exp_ke;
        q.push_back(n);
        issue_model_i.issue(op, s, m, ph, gap);
    endtask : send

    task automatic check_note(input note_t n);
        cmp_bit("opcode_error", n.err, opcode_error);
        cmp_bit("predicate_update", n.pu, predicate_update);
        cmp_bit("predicate_execute", n.pe, predicate_execute);
        cmp_bit("kill_update", n.ku, kill_predicate_update);
        cmp_bit("kill_execute", n.ke, kill_predicate_execute);
        if (!n.err) cmp_word("dst_even", n.de, dst_even);
        if (!n.err) cmp_word("dst_odd", n.dd, dst_odd);
        if (n.dbl) cmp_bit("dst_pair_high", n.ph, dst_pair_high);
    endtask : check_note

    task automatic chk_rst();
        exp_pe = 1'b0;
        exp_ke = 1'b0;
        @(negedge sys_clk);
        cmp_word("reset dst", 32'h0, dst_even | dst_odd);
        cmp_bit("reset levels", 1'b0, predicate_execute | kill_predicate_execute);
        cmp_bit("reset pulses", 1'b0, result_valid | predicate_update | kill_predicate_update | opcode_error);
        $display("test reset done");
    endtask : chk_rst

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // exactly one answer per taken issue, one cycle later
    always @(negedge sys_clk) begin
        if (!rst) begin
            cmp_bit("answer", prev_iv, result_valid | opcode_error);
            if (result_valid | opcode_error) begin
                cmp_bit("queued", 1'b1, q.size() != 0);
                if (q.size() != 0) check_note(q.pop_front());
            end
        end
        prev_iv = issue_valid && !rst;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    initial begin
        logic [127:0] s;
        void'($urandom(93868));
        rst = 1'b1;
        prev_iv = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        chk_rst();
        send(OP_DOUBLE_GE, {DT[0], DT[0]}, 4'h0, 1'b1, 0);
        send(OP_DOUBLE_GE, {DT[0], DT[1]}, 4'h0, 1'b1, 0);
        send(OP_DOUBLE_GE, {DT[1], DT[0]}, 4'h0, 1'b0, 2);
        foreach (DT[i]) begin
            foreach (DT[j]) begin
                send(OP_DOUBLE_GE, {DT[i], DT[j]}, 4'($urandom), 1'($urandom), $urandom % 2);
            end
        end
        issue_model_i.flush();
        $display("test double corners done");
        foreach (OPS[o]) begin
            repeat (40) begin
                s = {FT[$urandom % 9], 32'($urandom), FT[$urandom % 9], 32'($urandom)};
                if ($urandom % 3 == 0) s[127:96] = $urandom;
                if (OPS[o] == OP_FLOAT_GE_PUSH || OPS[o] == OP_INT_GE_PUSH) s[127:96] = PT[$urandom % 5];
                if ($urandom % 4 == 0) s[63:32] = s[127:96];
                send(OPS[o], s, 4'($urandom), 1'b0, $urandom % 2);
            end
            issue_model_i.flush();
            $display("test opcode %h done", OPS[o]);
        end
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        chk_rst();
        send(OP_SIGNED_GE, {32'h80000000, 32'h0, 32'h7FFFFFFF, 32'h0}, 4'hF, 1'b0, 0);
        send(OP_UNSIGNED_GE, {32'h80000000, 32'h0, 32'h7FFFFFFF, 32'h0}, 4'hF, 1'b0, 3);
        cmp_bit("drained", 1'b0, q.size() != 0);
        $display("test restart done");
        close_out();
    end
endmodule : tb
